// [verilog/fwdl_command_handler.sv]
`timescale 1ns/10ps
module fwdl_command_handler (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [fwdl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive condition, same clock
  input wire logic security_locked,
  input wire logic spinup_disabled,
  // sector stream
  input wire logic sector_done,
  output logic xfer_active,
  output logic [fwdl_pkg::IMG_ADDR_W-1:0] seg_byte_addr,
  // image verify and save
  input wire logic image_complete,
  input wire logic reload_requested,
  input wire logic save_done,
  input wire logic save_ok,
  output logic save_req,
  output logic fw_activate,
  output logic spin_down,
  output logic discard,
  // diagnostics
  input wire logic diag_done,
  input wire logic [7:0] diag_code,
  output logic diag_start,
  // cache flush
  input wire logic flush_done,
  input wire logic flush_ok,
  output logic flush_req,
  // other commands
  output logic other_start,
  output logic [7:0] other_code,
  // interrupt
  output logic irq
);

  fwdl_pkg::fwdl_regs_t r;
  fwdl_pkg::fwdl_regs_t next_r;

  logic acc;
  logic hs_wr;
  logic hs_rd;
  logic idle;
  logic cmd_wr;
  logic srst_wr;
  logic [15:0] cnt_val;
  logic [15:0] ofs_val;
  logic sub_ok;

  assign acc = psel & penable;
  assign hs_wr = acc & r.pready & pwrite;
  assign hs_rd = acc & r.pready & ~pwrite;
  assign idle = (r.phase == fwdl_pkg::PH_IDLE);
  // taskfile writes while busy are ignored, as on a real drive
  assign cmd_wr = hs_wr & idle & (paddr == fwdl_pkg::OFF_CMD);
  assign srst_wr = hs_wr & (paddr == fwdl_pkg::OFF_CTRL) & pwdata[fwdl_pkg::CTRL_SRST];
  // (R3) count high/low join
  assign cnt_val = {r.cnt_hi, r.cnt_lo};
  // (R10) offset from cylinder
  assign ofs_val = {r.ofs_hi, r.ofs_lo};
  // (R2) valid subcommand decode
  assign sub_ok = (r.subcmd == fwdl_pkg::SUB_OFFSETS) | (r.subcmd == fwdl_pkg::SUB_WHOLE);

  function automatic logic addr_mapped(input logic [fwdl_pkg::ADDR_W-1:0] a);
    addr_mapped = (a == fwdl_pkg::OFF_SUBCMD) | (a == fwdl_pkg::OFF_CNT_LO) |
      (a == fwdl_pkg::OFF_CNT_HI) | (a == fwdl_pkg::OFF_OFS_LO) |
      (a == fwdl_pkg::OFF_OFS_HI) | (a == fwdl_pkg::OFF_DRIVE) |
      (a == fwdl_pkg::OFF_CMD) | (a == fwdl_pkg::OFF_ERROR) |
      (a == fwdl_pkg::OFF_STATUS) | (a == fwdl_pkg::OFF_IRQ_STAT) |
      (a == fwdl_pkg::OFF_IRQ_MASK) | (a == fwdl_pkg::OFF_CTRL) |
      (a == fwdl_pkg::OFF_EXPECT);
  endfunction

  always_comb begin
    logic [fwdl_pkg::IRQ_W-1:0] ev;
    ev = '0;
    next_r = r;
    next_r.save_req = 1'b0;
    next_r.diag_start = 1'b0;
    next_r.flush_req = 1'b0;
    next_r.other_start = 1'b0;
    next_r.discard = 1'b0;
    next_r.fw_activate = 1'b0;
    next_r.spin_down = 1'b0;

    // answer one cycle into the access phase so every bus output is a flop
    next_r.pready = acc & ~r.pready;
    next_r.pslverr = acc & ~r.pready & ~addr_mapped(paddr);
    if (acc & ~r.pready & ~pwrite) begin
      unique case (paddr)
        fwdl_pkg::OFF_CNT_LO: next_r.prdata = {24'h000000, r.cnt_lo};
        fwdl_pkg::OFF_CNT_HI: next_r.prdata = {24'h000000, r.cnt_hi};
        fwdl_pkg::OFF_OFS_LO: next_r.prdata = {24'h000000, r.ofs_lo};
        fwdl_pkg::OFF_OFS_HI: next_r.prdata = {24'h000000, r.ofs_hi};
        fwdl_pkg::OFF_DRIVE: next_r.prdata = {24'h000000, r.drive};
        fwdl_pkg::OFF_ERROR: next_r.prdata = {24'h000000, r.error};
        fwdl_pkg::OFF_STATUS: next_r.prdata = {24'h000000, r.status};
        fwdl_pkg::OFF_IRQ_STAT: next_r.prdata = {29'h00000000, r.irq_stat};
        fwdl_pkg::OFF_IRQ_MASK: next_r.prdata = {29'h00000000, r.irq_mask};
        fwdl_pkg::OFF_EXPECT: next_r.prdata = {16'h0000, r.expect_ofs};
        default: next_r.prdata = 32'h00000000;
      endcase
    end

    if (hs_rd & (paddr == fwdl_pkg::OFF_IRQ_STAT)) begin
      next_r.irq_stat = '0;
    end
    if (hs_wr & (paddr == fwdl_pkg::OFF_IRQ_MASK)) begin
      next_r.irq_mask = pwdata[fwdl_pkg::IRQ_W-1:0];
    end
    if (hs_wr & idle) begin
      unique case (paddr)
        fwdl_pkg::OFF_SUBCMD: next_r.subcmd = pwdata[7:0];
        fwdl_pkg::OFF_CNT_LO: next_r.cnt_lo = pwdata[7:0];
        fwdl_pkg::OFF_CNT_HI: next_r.cnt_hi = pwdata[7:0];
        fwdl_pkg::OFF_OFS_LO: next_r.ofs_lo = pwdata[7:0];
        fwdl_pkg::OFF_OFS_HI: next_r.ofs_hi = pwdata[7:0];
        fwdl_pkg::OFF_DRIVE: next_r.drive = pwdata[7:0];
        default: next_r.drive = r.drive;
      endcase
    end

    if (srst_wr) begin
      // (R16) reset drops segments
      next_r.phase = fwdl_pkg::PH_IDLE;
      next_r.discard = r.seg_active;
      ev[fwdl_pkg::IRQ_DISCARD] = r.seg_active;
      next_r.seg_active = 1'b0;
      // (R19) clear on discard
      next_r.expect_ofs = '0;
      next_r.error = '0;
      next_r.status = fwdl_pkg::STATUS_READY;
    end else begin
      unique case (r.phase)
        fwdl_pkg::PH_IDLE: begin
          if (cmd_wr) begin
            next_r.error = '0;
            next_r.status = fwdl_pkg::STATUS_READY;
            // (R15) other command drops partial
            if ((pwdata[7:0] != fwdl_pkg::CMD_DOWNLOAD) & r.seg_active) begin
              next_r.discard = 1'b1;
              ev[fwdl_pkg::IRQ_DISCARD] = 1'b1;
              next_r.seg_active = 1'b0;
              next_r.expect_ofs = '0;
            end
            // (R1) decode download command
            if (pwdata[7:0] == fwdl_pkg::CMD_DOWNLOAD) begin
              // (R6) abort bad or locked
              if (~sub_ok | security_locked) begin
                next_r.error[fwdl_pkg::ERR_ABT] = 1'b1;
                next_r.status[fwdl_pkg::ST_ERR] = 1'b1;
                ev[fwdl_pkg::IRQ_DONE] = 1'b1;
              // (R12) out-of-order segment abort
              end else if ((r.subcmd == fwdl_pkg::SUB_OFFSETS) & (ofs_val != r.expect_ofs)) begin
                next_r.error[fwdl_pkg::ERR_ABT] = 1'b1;
                next_r.status[fwdl_pkg::ST_ERR] = 1'b1;
                next_r.discard = r.seg_active;
                ev[fwdl_pkg::IRQ_DISCARD] = r.seg_active;
                next_r.seg_active = 1'b0;
                next_r.expect_ofs = '0;
                ev[fwdl_pkg::IRQ_DONE] = 1'b1;
              // (R4) zero length, no data
              end else if (cnt_val == 16'h0000) begin
                ev[fwdl_pkg::IRQ_DONE] = 1'b1;
              end else begin
                // (R9) offset mode spans commands
                next_r.whole_mode = (r.subcmd == fwdl_pkg::SUB_WHOLE);
                if (r.subcmd == fwdl_pkg::SUB_WHOLE) begin
                  next_r.discard = r.seg_active;
                  ev[fwdl_pkg::IRQ_DISCARD] = r.seg_active;
                  next_r.seg_active = 1'b0;
                  next_r.expect_ofs = '0;
                end
                next_r.remain = cnt_val;
                next_r.seg_len = cnt_val;
                next_r.status = fwdl_pkg::STATUS_XFER;
                next_r.phase = fwdl_pkg::PH_XFER;
              end
            end else if (pwdata[7:0] == fwdl_pkg::CMD_DIAG) begin
              next_r.diag_start = 1'b1;
              next_r.status = fwdl_pkg::STATUS_BUSY;
              next_r.phase = fwdl_pkg::PH_DIAG;
            end else if (pwdata[7:0] == fwdl_pkg::CMD_FLUSH) begin
              next_r.flush_req = 1'b1;
              next_r.status = fwdl_pkg::STATUS_BUSY;
              next_r.phase = fwdl_pkg::PH_FLUSH;
            end else begin
              // handed to the rest of the drive, completes here at once
              next_r.other_start = 1'b1;
              next_r.other_code = pwdata[7:0];
              ev[fwdl_pkg::IRQ_DONE] = 1'b1;
            end
          end
        end
        fwdl_pkg::PH_XFER: begin
          // (R5) whole sectors only
          if (sector_done) begin
            next_r.remain = r.remain - 16'h0001;
            if (r.remain == 16'h0001) begin
              // (R19) advance expected offset
              next_r.expect_ofs = r.whole_mode ? 16'h0000 : r.expect_ofs + r.seg_len;
              next_r.seg_active = ~r.whole_mode;
              // (R13) last segment verify, save
              if (r.whole_mode | image_complete) begin
                next_r.save_req = 1'b1;
                next_r.status = fwdl_pkg::STATUS_BUSY;
                next_r.phase = fwdl_pkg::PH_SAVE;
              end else begin
                next_r.status = fwdl_pkg::STATUS_READY;
                ev[fwdl_pkg::IRQ_DONE] = 1'b1;
                next_r.phase = fwdl_pkg::PH_IDLE;
              end
            end
          end
        end
        fwdl_pkg::PH_SAVE: begin
          if (save_done) begin
            next_r.seg_active = 1'b0;
            next_r.expect_ofs = '0;
            next_r.status = fwdl_pkg::STATUS_READY;
            next_r.phase = fwdl_pkg::PH_IDLE;
            ev[fwdl_pkg::IRQ_DONE] = 1'b1;
            if (save_ok) begin
              // (R14) activate new firmware
              next_r.fw_activate = 1'b1;
              ev[fwdl_pkg::IRQ_SAVED] = 1'b1;
              // (R8) spin down after reload
              next_r.spin_down = reload_requested & spinup_disabled;
            // (R7) unc only when requested
            end else if (reload_requested) begin
              next_r.error[fwdl_pkg::ERR_UNC] = 1'b1;
              next_r.status[fwdl_pkg::ST_ERR] = 1'b1;
            end else begin
              next_r.error[fwdl_pkg::ERR_ABT] = 1'b1;
              next_r.status[fwdl_pkg::ST_ERR] = 1'b1;
            end
          end
        end
        fwdl_pkg::PH_DIAG: begin
          if (diag_done) begin
            // (R17) diagnostic code in error
            next_r.error = diag_code;
            next_r.status = fwdl_pkg::STATUS_READY;
            next_r.phase = fwdl_pkg::PH_IDLE;
            ev[fwdl_pkg::IRQ_DONE] = 1'b1;
          end
        end
        fwdl_pkg::PH_FLUSH: begin
          // (R18) good status after flush
          if (flush_done) begin
            next_r.status = fwdl_pkg::STATUS_READY;
            next_r.error[fwdl_pkg::ERR_ABT] = ~flush_ok;
            next_r.status[fwdl_pkg::ST_ERR] = ~flush_ok;
            next_r.phase = fwdl_pkg::PH_IDLE;
            ev[fwdl_pkg::IRQ_DONE] = 1'b1;
          end
        end
        default: next_r.phase = fwdl_pkg::PH_IDLE;
      endcase
    end

    // a new event wins over the clear-on-read in the same cycle
    next_r.irq_stat = next_r.irq_stat | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.status <= fwdl_pkg::STATUS_READY;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign xfer_active = r.status[fwdl_pkg::ST_DRQ];
  assign seg_byte_addr = {r.expect_ofs, {fwdl_pkg::SECTOR_SHIFT{1'b0}}};
  assign save_req = r.save_req;
  assign fw_activate = r.fw_activate;
  assign spin_down = r.spin_down;
  assign discard = r.discard;
  assign diag_start = r.diag_start;
  assign flush_req = r.flush_req;
  assign other_start = r.other_start;
  assign other_code = r.other_code;
  assign irq = r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic dl_wr;
  assign dl_wr = cmd_wr & (pwdata[7:0] == fwdl_pkg::CMD_DOWNLOAD) & ~srst_wr;

  bad_sub_abort_a: assert property ( // (R6)
    dl_wr & (~sub_ok | security_locked) |=>
      r.error[fwdl_pkg::ERR_ABT] & idle & ~xfer_active)
    else $error("bad subcommand or lock did not abort");

  count_join_a: assert property ( // (R3)
    dl_wr & sub_ok & ~security_locked & (r.phase == fwdl_pkg::PH_IDLE) ##1
      (r.phase == fwdl_pkg::PH_XFER) |-> r.remain == $past(cnt_val))
    else $error("transfer length not formed from count bytes");

  zero_len_a: assert property ( // (R4)
    dl_wr & sub_ok & ~security_locked & (cnt_val == 16'h0000) |=> idle [*2])
    else $error("zero length download started a transfer");

  order_abort_a: assert property ( // (R12)
    dl_wr & (r.subcmd == fwdl_pkg::SUB_OFFSETS) & ~security_locked &
      (ofs_val != r.expect_ofs) |=> r.error[fwdl_pkg::ERR_ABT] & (r.expect_ofs == 16'h0000))
    else $error("out of order segment not aborted");

  other_drop_a: assert property ( // (R15)
    cmd_wr & ~srst_wr & (pwdata[7:0] != fwdl_pkg::CMD_DOWNLOAD) & r.seg_active |=>
      discard & ~r.seg_active & (r.expect_ofs == 16'h0000))
    else $error("other command kept partial download");

  reset_drop_a: assert property ( // (R16)
    srst_wr |=> idle & ~r.seg_active & (r.expect_ofs == 16'h0000))
    else $error("reset kept partial download");

  save_last_a: assert property ( // (R13)
    (r.phase == fwdl_pkg::PH_XFER) & sector_done & (r.remain == 16'h0001) &
      (r.whole_mode | image_complete) & ~srst_wr |=> save_req ##1 (r.phase == fwdl_pkg::PH_SAVE))
    else $error("last segment not saved");

  offset_adv_a: assert property ( // (R19)
    (r.phase == fwdl_pkg::PH_XFER) & sector_done & (r.remain == 16'h0001) & ~r.whole_mode &
      ~image_complete & ~srst_wr |=> r.expect_ofs == $past(r.expect_ofs) + $past(r.seg_len))
    else $error("expected offset not advanced");

  diag_code_a: assert property ( // (R17)
    (r.phase == fwdl_pkg::PH_DIAG) & diag_done & ~srst_wr |=> r.error == $past(diag_code))
    else $error("diagnostic code not in error register");

  flush_busy_a: assert property ( // (R18)
    (r.phase == fwdl_pkg::PH_FLUSH) & ~flush_done |-> r.status[fwdl_pkg::ST_BSY])
    else $error("good status before flush done");

  unc_reload_a: assert property ( // (R7)
    (r.phase == fwdl_pkg::PH_SAVE) & save_done & ~srst_wr |=>
      r.error[fwdl_pkg::ERR_UNC] == ($past(reload_requested) & ~$past(save_ok)))
    else $error("uncorrectable flag wrong after reload");

  spin_down_a: assert property ( // (R8)
    spin_down |-> fw_activate & $past(reload_requested) & $past(spinup_disabled))
    else $error("spin down without requested reload");

  cover_whole_c: cover property (save_req ##[1:50] fw_activate);
  cover_order_c: cover property (dl_wr & (r.subcmd == fwdl_pkg::SUB_OFFSETS) ##1
    r.error[fwdl_pkg::ERR_ABT]);
  cover_drop_c: cover property (discard & (r.phase == fwdl_pkg::PH_IDLE));
  cover_flush_c: cover property ((r.phase == fwdl_pkg::PH_FLUSH) ##1 idle);

endmodule

// [verilog/fwdl_pkg.sv]
// Contract
// (R1) command 92h starts microcode download
// (R2) subcommand 03h offsets, 07h whole image
// (R3) sector count: high byte, low byte
// (R4) zero sector count means no data
// (R5) host sends whole sectors only
// (R6) abort on bad subcommand or security lock
// (R7) failed requested reload reports uncorrectable
// (R8) spin down after reload if spin-up disabled
// (R9) offset mode spans several download commands
// (R10) buffer offset from cylinder registers, 512-byte units
// (R11) host sends segments in order, first zero
// (R12) out-of-order segment aborts, drops segments
// (R13) last segment: verify then save image
// (R14) new firmware active after last segment
// (R15) other command drops partial download
// (R16) reset drops partial download first
// (R17) diagnostics put code in error register
// (R18) flush completes before good status
// (R19) expected offset kept, cleared on discard
package fwdl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SECTOR_BYTES = 512;
  localparam int unsigned SECTOR_SHIFT = $clog2(SECTOR_BYTES);
  localparam int unsigned IMG_ADDR_W = 16 + SECTOR_SHIFT;

  // register byte offsets
  localparam logic [7:0] OFF_SUBCMD = 8'h00;
  localparam logic [7:0] OFF_CNT_LO = 8'h04;
  localparam logic [7:0] OFF_CNT_HI = 8'h08;
  localparam logic [7:0] OFF_OFS_LO = 8'h0c;
  localparam logic [7:0] OFF_OFS_HI = 8'h10;
  localparam logic [7:0] OFF_DRIVE = 8'h14;
  localparam logic [7:0] OFF_CMD = 8'h18;
  localparam logic [7:0] OFF_ERROR = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2c;
  localparam logic [7:0] OFF_EXPECT = 8'h30;

  // command and subcommand codes
  localparam logic [7:0] CMD_DOWNLOAD = 8'h92;
  localparam logic [7:0] CMD_DIAG = 8'h90;
  localparam logic [7:0] CMD_FLUSH = 8'he7;
  localparam logic [7:0] SUB_OFFSETS = 8'h03;
  localparam logic [7:0] SUB_WHOLE = 8'h07;

  // error and status bit positions
  localparam int unsigned ERR_ABT = 2;
  localparam int unsigned ERR_UNC = 6;
  localparam int unsigned ST_BSY = 7;
  localparam int unsigned ST_RDY = 6;
  localparam int unsigned ST_DSC = 4;
  localparam int unsigned ST_DRQ = 3;
  localparam int unsigned ST_ERR = 0;
  localparam logic [7:0] STATUS_READY = 8'h50;
  localparam logic [7:0] STATUS_BUSY = 8'h80;
  localparam logic [7:0] STATUS_XFER = 8'h58;

  // interrupt status bits, control bits
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_DISCARD = 1;
  localparam int unsigned IRQ_SAVED = 2;
  localparam int unsigned CTRL_SRST = 0;

  typedef enum logic [2:0] {PH_IDLE, PH_XFER, PH_SAVE, PH_DIAG, PH_FLUSH} fwdl_phase_t;

  typedef struct packed {
    fwdl_phase_t phase;
    logic [7:0] subcmd;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] ofs_lo;
    logic [7:0] ofs_hi;
    logic [7:0] drive;
    logic [7:0] error;
    logic [7:0] status;
    logic [15:0] remain;
    logic [15:0] seg_len;
    logic [15:0] expect_ofs;
    logic seg_active;
    logic whole_mode;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic save_req;
    logic diag_start;
    logic flush_req;
    logic other_start;
    logic [7:0] other_code;
    logic discard;
    logic fw_activate;
    logic spin_down;
  } fwdl_regs_t;

endpackage

// [verification/fwdl_backend_model.sv]
`timescale 1ns/10ps
module fwdl_backend_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // behaviour chosen by the bench
  input wire logic cfg_slow,
  input wire logic cfg_ok,
  input wire logic cfg_reload,
  input wire logic [7:0] cfg_code,
  // handler requests
  input wire logic xfer_active,
  input wire logic save_req,
  input wire logic diag_start,
  input wire logic flush_req,
  // answers
  output logic sector_done,
  output logic save_done,
  output logic save_ok,
  output logic reload_requested,
  output logic diag_done,
  output logic [7:0] diag_code,
  output logic flush_done,
  output logic flush_ok
);
  logic [1:0] gap;
  logic [11:0] dly;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap <= 2'h0;
      dly <= 12'h000;
      sector_done <= 1'b0;
    end else begin
      gap <= (gap == 2'h0) ? {cfg_slow, 1'b0} : gap - 2'h1;
      sector_done <= xfer_active && gap == 2'h0;
      dly <= {dly[8:0], save_req, diag_start, flush_req};
    end
  end
  assign save_done = dly[11];
  assign diag_done = dly[10];
  assign flush_done = dly[9];
  // outside the done pulse the lines show the inverse, so stale values cannot pass
  // save, reload, diagnostic and flush result lines
  assign save_ok = save_done ? cfg_ok : !cfg_ok;
  assign reload_requested = save_done ? cfg_reload : !cfg_reload;
  assign diag_code = diag_done ? cfg_code : ~cfg_code;
  assign flush_ok = flush_done ? cfg_ok : !cfg_ok;
endmodule

// [verification/test_firmware_download_command_handler.sv]
`timescale 1ns/10ps
module test_firmware_download_command_handler;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic security_locked = 1'b0;
  logic spinup_disabled = 1'b0;
  logic image_complete = 1'b0;
  logic cfg_slow = 1'b0;
  logic cfg_ok = 1'b1;
  logic cfg_reload = 1'b0;
  logic [7:0] cfg_code = 8'h00;
  logic [31:0] prdata;
  logic pready, pslverr, sector_done, xfer_active, save_done, save_ok, reload_requested;
  logic save_req, fw_activate, spin_down, discard, diag_done, diag_start;
  logic flush_done, flush_ok, flush_req, other_start, irq;
  logic [7:0] diag_code, other_code;
  logic [fwdl_pkg::IMG_ADDR_W-1:0] seg_byte_addr;
  logic [7:0] bad [5] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'hff};
  int fails = 0;
  int samples_checked = 0;
  int n_sec = 0, n_save = 0, n_act = 0, n_spin = 0, n_disc = 0, n_diag = 0, n_flush = 0;
  int n_other = 0;

  fwdl_command_handler i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .security_locked(security_locked), .spinup_disabled(spinup_disabled),
    .sector_done(sector_done), .xfer_active(xfer_active), .seg_byte_addr(seg_byte_addr),
    .image_complete(image_complete), .reload_requested(reload_requested),
    .save_done(save_done), .save_ok(save_ok), .save_req(save_req),
    .fw_activate(fw_activate), .spin_down(spin_down), .discard(discard),
    .diag_done(diag_done), .diag_code(diag_code), .diag_start(diag_start),
    .flush_done(flush_done), .flush_ok(flush_ok), .flush_req(flush_req),
    .other_start(other_start), .other_code(other_code), .irq(irq)
  );

  fwdl_backend_model i_far (
    .pclk(pclk), .presetn(presetn), .cfg_slow(cfg_slow), .cfg_ok(cfg_ok),
    .cfg_reload(cfg_reload), .cfg_code(cfg_code), .xfer_active(xfer_active),
    .save_req(save_req), .diag_start(diag_start), .flush_req(flush_req),
    .sector_done(sector_done), .save_done(save_done), .save_ok(save_ok),
    .reload_requested(reload_requested), .diag_done(diag_done), .diag_code(diag_code),
    .flush_done(flush_done), .flush_ok(flush_ok)
  );

  always #10 pclk = ~pclk;

  // pulses stand one cycle, so the falling edge sees each exactly once
  always @(negedge pclk) begin
    n_sec += int'(sector_done === 1'b1 && xfer_active === 1'b1);
    n_save += int'(save_req === 1'b1);
    n_act += int'(fw_activate === 1'b1);
    n_spin += int'(spin_down === 1'b1);
    n_disc += int'(discard === 1'b1);
    n_diag += int'(diag_start === 1'b1);
    n_flush += int'(flush_req === 1'b1);
    n_other += int'(other_start === 1'b1);
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // pready, prdata and pslverr are taken at the rising edge that closes the access phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      complete_run();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    bus(a, 1'b1, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic e;
    bus(a, 1'b0, 32'h0, r, e);
    chk(nm, exp, r);
  endtask

  task automatic cmd(input logic [7:0] sub, input logic [15:0] cnt, input logic [15:0] ofs,
                     input logic [7:0] code);
    logic [31:0] r;
    logic e;
    int n;
    wr(fwdl_pkg::OFF_SUBCMD, {24'h0, sub});
    wr(fwdl_pkg::OFF_CNT_LO, {24'h0, cnt[7:0]});
    wr(fwdl_pkg::OFF_CNT_HI, {24'h0, cnt[15:8]});
    wr(fwdl_pkg::OFF_OFS_LO, {24'h0, ofs[7:0]});
    wr(fwdl_pkg::OFF_OFS_HI, {24'h0, ofs[15:8]});
    wr(fwdl_pkg::OFF_CMD, {24'h0, code});
    n = 0;
    do begin
      bus(fwdl_pkg::OFF_STATUS, 1'b0, 32'h0, r, e);
      n++;
    end while ((r[7] | r[3]) !== 1'b0 && n < 400);
    if (n >= 400) begin
      fails++;
      complete_run();
    end
  endtask

  initial begin
    #1000000;
    fails++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    logic e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(fwdl_pkg::OFF_STATUS, 32'h50, "status");
    rd(fwdl_pkg::OFF_ERROR, 32'h0, "error");
    bus(8'h34, 1'b0, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    foreach (bad[i]) begin
      cmd(bad[i], 16'h0001, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
      rd(fwdl_pkg::OFF_ERROR, 32'h04, "abort");
      rd(fwdl_pkg::OFF_STATUS, 32'h51, "status");
    end
    security_locked <= 1'b1;
    cmd(fwdl_pkg::SUB_WHOLE, 16'h0001, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    rd(fwdl_pkg::OFF_ERROR, 32'h04, "locked");
    security_locked <= 1'b0;
    cfg_reload <= 1'b1;
    spinup_disabled <= 1'b1;
    cmd(fwdl_pkg::SUB_WHOLE, 16'h0102, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    chk("sectors", 258, n_sec);
    chk("saves", 1, n_save);
    chk("activate", 1, n_act);
    chk("spin down", 1, n_spin);
    rd(fwdl_pkg::OFF_ERROR, 32'h0, "error");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(fwdl_pkg::OFF_IRQ_MASK, 32'h7);
    rd(fwdl_pkg::OFF_IRQ_MASK, 32'h7, "mask");
    chk("irq on", 32'h1, {31'h0, irq});
    rd(fwdl_pkg::OFF_IRQ_STAT, 32'h5, "irq stat");
    rd(fwdl_pkg::OFF_IRQ_STAT, 32'h0, "irq cleared");
    chk("irq off", 32'h0, {31'h0, irq});
    wr(fwdl_pkg::OFF_IRQ_MASK, 32'h0);
    cmd(fwdl_pkg::SUB_WHOLE, 16'h0, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    chk("no data", 258, n_sec);
    chk("no save", 1, n_save);
    cfg_slow <= 1'b1;
    cmd(fwdl_pkg::SUB_OFFSETS, 16'h0003, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    rd(fwdl_pkg::OFF_EXPECT, 32'h3, "next offset");
    chk("byte addr", 32'h600, {7'h0, seg_byte_addr});
    cmd(fwdl_pkg::SUB_OFFSETS, 16'h0001, 16'h0103, fwdl_pkg::CMD_DOWNLOAD);
    rd(fwdl_pkg::OFF_ERROR, 32'h04, "gap abort");
    chk("discards", 1, n_disc);
    rd(fwdl_pkg::OFF_EXPECT, 32'h0, "cleared");
    cmd(fwdl_pkg::SUB_OFFSETS, 16'h0002, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    cmd(8'h00, 16'h0, 16'h0, 8'hc8);
    chk("other", 1, n_other);
    chk("other code", 32'hc8, {24'h0, other_code});
    chk("discards", 2, n_disc);
    rd(fwdl_pkg::OFF_EXPECT, 32'h0, "cleared");
    cmd(fwdl_pkg::SUB_OFFSETS, 16'h0002, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    wr(fwdl_pkg::OFF_CTRL, 32'h1);
    rd(fwdl_pkg::OFF_EXPECT, 32'h0, "soft reset");
    chk("discards", 3, n_disc);
    cmd(fwdl_pkg::SUB_OFFSETS, 16'h0002, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(fwdl_pkg::OFF_EXPECT, 32'h0, "hard reset");
    cfg_ok <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      cfg_reload <= (i == 1);
      image_complete <= 1'b0;
      cmd(fwdl_pkg::SUB_OFFSETS, 16'h0002, 16'h0, fwdl_pkg::CMD_DOWNLOAD);
      image_complete <= 1'b1;
      cmd(fwdl_pkg::SUB_OFFSETS, 16'h0001, 16'h0002, fwdl_pkg::CMD_DOWNLOAD);
      rd(fwdl_pkg::OFF_ERROR, (i == 1) ? 32'h40 : 32'h04, "save error");
    end
    chk("saves", 3, n_save);
    chk("activate", 1, n_act);
    cfg_code <= 8'h81;
    cmd(8'h00, 16'h0, 16'h0, fwdl_pkg::CMD_DIAG);
    chk("diag", 1, n_diag);
    rd(fwdl_pkg::OFF_ERROR, 32'h81, "diag code");
    for (int i = 0; i < 2; i++) begin
      cfg_ok <= (i == 0);
      cmd(8'h00, 16'h0, 16'h0, fwdl_pkg::CMD_FLUSH);
      rd(fwdl_pkg::OFF_STATUS, (i == 1) ? 32'h51 : 32'h50, "flush status");
    end
    chk("flushes", 2, n_flush);
    complete_run();
  end
endmodule
